// File: hdl/cmd_delay_line.sv
`timescale 1ns/1ps
module cmd_delay_line
  import ddr2_cmd_pkg::*;
#(
  parameter int W = 14,
  parameter int DEPTH = MAX_POSTED
)
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  input wire logic [$clog2(DEPTH+1)-1:0] delay,
  output logic out_valid,
  output logic [W-1:0] out_data
);

  if (DEPTH < 1 || W < 1)
  begin : g_bad_size
    $error("cmd_delay_line needs DEPTH and W of at least one");
  end

  logic vld_q [DEPTH];
  logic vld_d [DEPTH];
  logic [W-1:0] dat_q [DEPTH];
  logic [W-1:0] dat_d [DEPTH];

  // ****************************************
  // Shift stages
  // ****************************************
  genvar i;
  generate
    for (i = 0; i < DEPTH; i++)
    begin : g_stage
      always_comb
      begin
        vld_d[i] = (i == 0) ? in_valid : vld_q[(i == 0) ? 0 : i-1];
        dat_d[i] = (i == 0) ? in_data : dat_q[(i == 0) ? 0 : i-1];
      end

      always_ff @(posedge core_clk)
      begin
        if (!resetn)
        begin
          vld_q[i] <= 1'b0;
          dat_q[i] <= '0;
        end
        else
        begin
          vld_q[i] <= vld_d[i];
          dat_q[i] <= dat_d[i];
        end
      end
    end
  endgenerate

  // Zero delay passes the command straight through
  always_comb
  begin
    out_valid = in_valid;
    out_data = in_data;
    if (delay != '0)
    begin
      out_valid = vld_q[delay - 1'b1];
      out_data = dat_q[delay - 1'b1];
    end
  end

endmodule

// File: hdl/ddr2_cmd_pkg.sv
package ddr2_cmd_pkg;

  // ****************************************
  // Geometry
  // ****************************************
  localparam int NUM_BANKS = 4;
  localparam int BA_W = 2;
  localparam int ADDR_W = 14;
  localparam int COL_W = 10;
  localparam int DATA_W = 8;
  localparam int AP_BIT = 10;
  localparam int NUM_MODE_REGS = 4;

  // ****************************************
  // Mode register fields and reset values
  // ****************************************
  localparam int EXT_MODE_IDX = 1;
  localparam int POSTED_POS = 3;
  localparam int POSTED_W = 3;
  localparam int TERM_EN_LO_POS = 2;
  localparam int TERM_EN_HI_POS = 6;
  localparam logic [ADDR_W-1:0] MODE_RESET = 14'h0000;
  localparam logic [ADDR_W-1:0] REFRESH_ROW_RESET = 14'h0000;

  // ****************************************
  // Timing counts in core_clk cycles
  // ****************************************
  localparam int BURST_LEN = 4;
  localparam int MAX_POSTED = 6;
  localparam int ROW_PRECHARGE_CYC = 3;
  localparam int MODE_SET_GAP_CYC = 2;
  localparam int TERM_ON_DELAY_CYC = 2;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    CMD_DESELECT,
    CMD_NOP,
    CMD_MODE_LOAD,
    CMD_REFRESH,
    CMD_PRECHARGE,
    CMD_ACTIVATE,
    CMD_WRITE,
    CMD_READ
  } cmd_t;

  typedef enum logic [1:0] {
    BANK_IDLE,
    BANK_ACTIVE,
    BANK_PRECHARGING
  } bank_state_t;

  function automatic cmd_t decode_cmd(input logic cs_n, input logic ras_n,
                                      input logic cas_n, input logic we_n);
    cmd_t c;
    c = CMD_NOP;
    if (cs_n)
    begin
      c = CMD_DESELECT;
    end
    else
    begin
      unique case ({ras_n, cas_n, we_n})
        3'h0: c = CMD_MODE_LOAD;
        3'h1: c = CMD_REFRESH;
        3'h2: c = CMD_PRECHARGE;
        3'h3: c = CMD_ACTIVATE;
        3'h4: c = CMD_WRITE;
        3'h5: c = CMD_READ;
        default: c = CMD_NOP;
      endcase
    end
    return c;
  endfunction

endpackage

// File: hdl/ddr2_command_bank_protocol.sv
`timescale 1ns/1ps
// Notes on behaviour
// RULE1 - Deselect or nop starts nothing new
// RULE2 - Mode load: bank picks register, address loads
// RULE3 - Mode load only with all banks idle; the code loads the register with banks open too
// RULE4 - Activate opens addressed row in bank
// RULE5 - Row stays open until bank precharged
// RULE6 - Read bursts from column on low address
// RULE7 - Auto precharge flag closes row after read
// RULE8 - Write bursts; auto precharge closes row after
// RULE9 - Posted delay postpones read/write registration
// RULE10 - Mask low writes beat, high skips it
// RULE11 - Precharge closes one or all banks
// RULE12 - Other-bank access allowed during auto precharge
// RULE13 - Precharged bank idle, needs activate again
// RULE14 - Precharge restarts timer, even if precharging
// RULE15 - Refresh only with all banks idle; the code advances the row with banks open too
// RULE16 - Internal counter supplies refresh row
// RULE17 - Refresh with clock gate low: self refresh
// RULE18 - Delay loop off during self refresh
// RULE19 - Controller keeps termination timing around update
// RULE20 - Termination follows input except self refresh
// RULE21 - Termination covers data, strobes and masks
// RULE22 - Precharge power-down uses direct termination timing
// RULE23 - Commands decoded on rising edge with gate
// RULE24 - Clock gate held three edges per change
// RULE25 - Only nop/deselect right after self refresh
// RULE26 - Timing limits are cycle count parameters
module ddr2_command_bank_protocol
  import ddr2_cmd_pkg::*;
#(
  parameter int BURST = BURST_LEN,
  parameter int POSTED_MAX = MAX_POSTED,
  parameter int PRECHARGE_CYC = ROW_PRECHARGE_CYC,
  parameter int MODE_GAP_CYC = MODE_SET_GAP_CYC,
  parameter int TERM_DLY_CYC = TERM_ON_DELAY_CYC
)
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [BA_W-1:0] ba,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic write_byte_mask,
  input wire logic termination_control,
  output logic [NUM_BANKS-1:0] bank_open,
  output logic [NUM_BANKS-1:0] bank_precharging,
  output logic [NUM_MODE_REGS-1:0][ADDR_W-1:0] mode_regs,
  output logic mode_busy,
  output logic selfref_active,
  output logic powerdown_active,
  output logic dll_enable,
  output logic term_enable,
  output logic refresh_pulse,
  output logic [ADDR_W-1:0] refresh_row,
  output logic array_wr_en,
  output logic array_rd_en,
  output logic [BA_W-1:0] array_bank,
  output logic [ADDR_W-1:0] array_row,
  output logic [COL_W-1:0] array_col,
  output logic [DATA_W-1:0] array_wr_data
);

  localparam int DLY_W = $clog2(POSTED_MAX + 1);
  localparam int CNT_W = $clog2(BURST + 1);
  localparam int TMR_W = 8;
  localparam int CMD_W = 2 + BA_W + COL_W;

  // Timers are eight bits wide, so longer counts are refused up front
  if (BURST < 1 || PRECHARGE_CYC < 1 || PRECHARGE_CYC > 255 || MODE_GAP_CYC > 255)
  begin : g_bad_timing
    $error("ddr2_command_bank_protocol: timing parameter out of range");
  end
  if (TERM_DLY_CYC < 2 || POSTED_MAX < 1)
  begin : g_bad_delay
    $error("ddr2_command_bank_protocol: delay parameter out of range");
  end

  // ****************************************
  // Command decode and power states
  // ****************************************
  cmd_t cmd;
  logic cke_q, cke_d;
  logic selfref_q, selfref_d;
  logic pd_q, pd_d;
  logic cmd_live;
  logic all_idle;
  bank_state_t st_q [NUM_BANKS];
  bank_state_t st_d [NUM_BANKS];

  assign cmd = decode_cmd(cs_n, ras_n, cas_n, we_n); // RULE23
  // Clock gate high on both edges and no low-power state: command executes
  assign cmd_live = cke_q && cke && !selfref_q && !pd_q; // RULE23 RULE1

  always_comb
  begin
    all_idle = 1'b1;
    for (int b = 0; b < NUM_BANKS; b++)
      if (st_q[b] != BANK_IDLE)
        all_idle = 1'b0;
  end

  always_comb
  begin
    cke_d = cke;
    selfref_d = selfref_q;
    pd_d = pd_q;
    if (!cke_q && cke)
    begin
      // Any high sample of the gate ends either low-power state
      selfref_d = 1'b0;
      pd_d = 1'b0;
    end
    else if (cke_q && !cke && !selfref_q && !pd_q)
    begin
      if (cmd == CMD_REFRESH && all_idle)
        selfref_d = 1'b1; // RULE17
      else if (cmd == CMD_NOP || cmd == CMD_DESELECT)
        pd_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      cke_q <= 1'b0;
      selfref_q <= 1'b0;
      pd_q <= 1'b0;
    end
    else
    begin
      cke_q <= cke_d;
      selfref_q <= selfref_d;
      pd_q <= pd_d;
    end
  end

  assign selfref_active = selfref_q;
  assign powerdown_active = pd_q;
  assign dll_enable = !selfref_q; // RULE18

  // ****************************************
  // Mode registers
  // ****************************************
  logic [ADDR_W-1:0] mode_q [NUM_MODE_REGS];
  logic [ADDR_W-1:0] mode_d [NUM_MODE_REGS];
  logic [TMR_W-1:0] gap_q, gap_d;
  logic [POSTED_W-1:0] posted_raw;
  logic [DLY_W-1:0] posted_cmd_delay;

  always_comb
  begin
    for (int m = 0; m < NUM_MODE_REGS; m++)
      mode_d[m] = mode_q[m];
    gap_d = (gap_q != '0) ? gap_q - 1'b1 : gap_q;
    // Loads while banks are busy are the controller's fault; still honoured
    if (cmd_live && cmd == CMD_MODE_LOAD)
    begin
      mode_d[ba] = addr; // RULE2
      gap_d = TMR_W'(MODE_GAP_CYC); // RULE26
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      for (int m = 0; m < NUM_MODE_REGS; m++)
        mode_q[m] <= MODE_RESET;
      gap_q <= '0;
    end
    else
    begin
      mode_q <= mode_d;
      gap_q <= gap_d;
    end
  end

  always_comb
  begin
    for (int m = 0; m < NUM_MODE_REGS; m++)
      mode_regs[m] = mode_q[m];
  end

  assign mode_busy = (gap_q != '0);
  assign posted_raw = mode_q[EXT_MODE_IDX][POSTED_POS +: POSTED_W];
  // Settings beyond the line length saturate rather than wrap
  assign posted_cmd_delay = (int'(posted_raw) > POSTED_MAX) ? DLY_W'(POSTED_MAX)
                                                           : DLY_W'(posted_raw);

  // ****************************************
  // Posted read and write registration
  // ****************************************
  logic acc_in_valid;
  logic [CMD_W-1:0] acc_in_data;
  logic acc_valid;
  logic [CMD_W-1:0] acc_data;

  assign acc_in_valid = cmd_live && (cmd == CMD_WRITE || cmd == CMD_READ);
  assign acc_in_data = {cmd == CMD_WRITE, addr[AP_BIT], ba, addr[COL_W-1:0]}; // RULE6 RULE8

  cmd_delay_line #(
    .W(CMD_W),
    .DEPTH(POSTED_MAX)
  ) u_posted (
    .core_clk(core_clk),
    .resetn(resetn),
    .in_valid(acc_in_valid),
    .in_data(acc_in_data),
    .delay(posted_cmd_delay), // RULE9
    .out_valid(acc_valid),
    .out_data(acc_data)
  );

  // ****************************************
  // Burst engine
  // ****************************************
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic bwr_q, bwr_d;
  logic bap_q, bap_d;
  logic [BA_W-1:0] bbank_q, bbank_d;
  logic [COL_W-1:0] bcol_q, bcol_d;
  logic wr_en_d, rd_en_d;
  logic [BA_W-1:0] abank_d;
  logic [COL_W-1:0] acol_d;
  logic [DATA_W-1:0] adata_d;
  logic ap_fire;
  logic [ADDR_W-1:0] row_q [NUM_BANKS];
  logic [ADDR_W-1:0] row_d [NUM_BANKS];

  always_comb
  begin
    cnt_d = cnt_q;
    bwr_d = bwr_q;
    bap_d = bap_q;
    bbank_d = bbank_q;
    bcol_d = bcol_q;
    wr_en_d = 1'b0;
    rd_en_d = 1'b0;
    abank_d = array_bank;
    acol_d = array_col;
    adata_d = array_wr_data;
    ap_fire = 1'b0;
    if (cnt_q != '0)
    begin
      wr_en_d = bwr_q && !write_byte_mask; // RULE10
      rd_en_d = !bwr_q;
      abank_d = bbank_q;
      acol_d = bcol_q;
      adata_d = wr_data;
      bcol_d = bcol_q + 1'b1;
      cnt_d = cnt_q - 1'b1;
      ap_fire = (cnt_q == CNT_W'(1)) && bap_q; // RULE7 RULE8
    end
    // A newly registered access cuts off the running burst
    if (acc_valid)
    begin
      cnt_d = CNT_W'(BURST);
      {bwr_d, bap_d, bbank_d, bcol_d} = acc_data;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      cnt_q <= '0;
      bwr_q <= 1'b0;
      bap_q <= 1'b0;
      bbank_q <= '0;
      bcol_q <= '0;
      array_wr_en <= 1'b0;
      array_rd_en <= 1'b0;
      array_bank <= '0;
      array_row <= '0;
      array_col <= '0;
      array_wr_data <= '0;
    end
    else
    begin
      cnt_q <= cnt_d;
      bwr_q <= bwr_d;
      bap_q <= bap_d;
      bbank_q <= bbank_d;
      bcol_q <= bcol_d;
      array_wr_en <= wr_en_d;
      array_rd_en <= rd_en_d;
      array_bank <= abank_d;
      array_row <= row_q[abank_d];
      array_col <= acol_d;
      array_wr_data <= adata_d;
    end
  end

  // ****************************************
  // Bank states
  // ****************************************
  logic [TMR_W-1:0] tmr_q [NUM_BANKS];
  logic [TMR_W-1:0] tmr_d [NUM_BANKS];

  always_comb
  begin
    for (int b = 0; b < NUM_BANKS; b++)
    begin
      st_d[b] = st_q[b];
      row_d[b] = row_q[b];
      tmr_d[b] = (tmr_q[b] != '0) ? tmr_q[b] - 1'b1 : tmr_q[b];
      if (st_q[b] == BANK_PRECHARGING && tmr_q[b] == '0)
        st_d[b] = BANK_IDLE; // RULE13
      if (cmd_live && cmd == CMD_ACTIVATE && ba == BA_W'(b) && st_q[b] == BANK_IDLE)
      begin
        st_d[b] = BANK_ACTIVE; // RULE4 RULE5
        row_d[b] = addr;
      end
      // Other banks keep serving bursts while this one auto precharges
      if ((ap_fire && bbank_q == BA_W'(b)) ||
          (cmd_live && cmd == CMD_PRECHARGE && (addr[AP_BIT] || ba == BA_W'(b))))
      begin
        if (st_q[b] != BANK_IDLE)
        begin
          st_d[b] = BANK_PRECHARGING; // RULE11 RULE12
          tmr_d[b] = TMR_W'(PRECHARGE_CYC - 1); // RULE14 RULE26
        end
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      for (int b = 0; b < NUM_BANKS; b++)
      begin
        st_q[b] <= BANK_IDLE;
        row_q[b] <= '0;
        tmr_q[b] <= '0;
      end
    end
    else
    begin
      st_q <= st_d;
      row_q <= row_d;
      tmr_q <= tmr_d;
    end
  end

  always_comb
  begin
    for (int b = 0; b < NUM_BANKS; b++)
    begin
      bank_open[b] = (st_q[b] == BANK_ACTIVE);
      bank_precharging[b] = (st_q[b] == BANK_PRECHARGING);
    end
  end

  // ****************************************
  // Refresh row counter
  // ****************************************
  logic [ADDR_W-1:0] ref_row_q, ref_row_d;
  logic ref_pulse_d;
  logic ref_hit;

  // Address pins are never looked at here
  assign ref_hit = (cmd_live || (cke_q && !selfref_q && !pd_q)) && cmd == CMD_REFRESH;

  always_comb
  begin
    ref_row_d = ref_row_q;
    ref_pulse_d = 1'b0;
    if (ref_hit)
    begin
      ref_row_d = ref_row_q + 1'b1; // RULE16
      ref_pulse_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      ref_row_q <= REFRESH_ROW_RESET;
      refresh_pulse <= 1'b0;
    end
    else
    begin
      ref_row_q <= ref_row_d;
      refresh_pulse <= ref_pulse_d;
    end
  end

  assign refresh_row = ref_row_q;

  // ****************************************
  // On-die termination
  // ****************************************
  logic term_s1_q, term_s2_q;
  logic [TERM_DLY_CYC-1:0] term_dly_q, term_dly_d;
  logic term_d;
  logic term_cfg;
  logic pd_timing;

  // Termination pin may move while the gate is low, so it is synchronised
  assign term_cfg = mode_q[EXT_MODE_IDX][TERM_EN_LO_POS] | mode_q[EXT_MODE_IDX][TERM_EN_HI_POS];
  assign pd_timing = pd_q && all_idle; // RULE22

  always_comb
  begin
    term_dly_d = {term_dly_q[TERM_DLY_CYC-2:0], term_s2_q};
    // Trade-off: direct path in precharge power-down costs the pipelined alignment
    term_d = pd_timing ? term_s2_q : term_dly_q[TERM_DLY_CYC-1]; // RULE22
    term_d = term_d && term_cfg && !selfref_q; // RULE20 RULE21
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      term_s1_q <= 1'b0;
      term_s2_q <= 1'b0;
      term_dly_q <= '0;
      term_enable <= 1'b0;
    end
    else
    begin
      term_s1_q <= termination_control;
      term_s2_q <= term_s1_q;
      term_dly_q <= term_dly_d;
      term_enable <= term_d;
    end
  end

endmodule

// File: sim/ctrl_model.sv
`timescale 1ns/1ps
module ctrl_model
  import ddr2_cmd_pkg::*;
(
  input wire logic core_clk,
  output logic cke,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [BA_W-1:0] ba,
  output logic [ADDR_W-1:0] addr,
  output logic [DATA_W-1:0] wr_data,
  output logic write_byte_mask
);
  // ****
  // Command issue, held until the sampling edge
  // ****
  initial
  begin
    {cke, cs_n, ras_n, cas_n, we_n} = 5'h1F;
    ba = '0;
    addr = '0;
    wr_data = '0;
    write_byte_mask = 1'b1;
  end
  task automatic issue(input logic sel, input logic [2:0] c, input logic [BA_W-1:0] b,
                       input logic [ADDR_W-1:0] a, input logic k);
    logic ko;
    ko = cke;
    @(posedge core_clk);
    cs_n <= sel;
    {ras_n, cas_n, we_n} <= c;
    ba <= b;
    addr <= a;
    cke <= k;
    @(posedge core_clk);
    cs_n <= 1'b0;
    {ras_n, cas_n, we_n} <= 3'h7;
    // Released lines flip so a stale copy never looks valid
    ba <= ~b;
    addr <= ~a;
    if (k !== ko) repeat (2) @(posedge core_clk);
  endtask
  task automatic beats(input logic [DATA_W-1:0] d0, input logic [3:0] m);
    int k;
    for (k = 0; k < 4; k++)
    begin
      wr_data <= d0 + 8'(k);
      write_byte_mask <= m[k];
      @(posedge core_clk);
    end
    wr_data <= ~(d0 + 8'h03);
    write_byte_mask <= ~m[3];
  endtask
  task automatic mode_load(input logic [BA_W-1:0] b, input logic [ADDR_W-1:0] a);
    issue(1'b0, 3'h0, b, a, 1'b1);
    repeat (MODE_SET_GAP_CYC) @(posedge core_clk);
  endtask
  task automatic wake;
    issue(1'b1, 3'h7, '0, '0, 1'b1);
    repeat (200) @(posedge core_clk);
  endtask
endmodule

// File: sim/ddr2_cmd_checker.sv
`timescale 1ns/1ps
module ddr2_cmd_checker
  import ddr2_cmd_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [BA_W-1:0] ba,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic write_byte_mask,
  input wire logic [NUM_BANKS-1:0] bank_open,
  input wire logic [NUM_BANKS-1:0] bank_precharging,
  input wire logic [NUM_MODE_REGS-1:0][ADDR_W-1:0] mode_regs,
  input wire logic mode_busy,
  input wire logic selfref_active,
  input wire logic powerdown_active,
  input wire logic dll_enable,
  input wire logic term_enable,
  input wire logic refresh_pulse,
  input wire logic [ADDR_W-1:0] refresh_row,
  input wire logic array_wr_en,
  input wire logic array_rd_en,
  input wire logic [BA_W-1:0] array_bank,
  input wire logic [COL_W-1:0] array_col,
  input wire logic [DATA_W-1:0] array_wr_data
);
  // ****
  // Command decode
  // ****
  logic cke_q;
  always_ff @(posedge core_clk)
  begin
    cke_q <= resetn ? cke : 1'b0;
  end
  wire live = cke && cke_q && !selfref_active && !powerdown_active && !cs_n;
  wire [2:0] code = {ras_n, cas_n, we_n};
  wire idle = (bank_open == '0) && (bank_precharging == '0);
  wire [2:0] al = mode_regs[EXT_MODE_IDX][5:3];
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  sequence wr_cmd;
    live && code == 3'h4 && al == 3'h0;
  endsequence
  sequence rd_late;
    live && code == 3'h5 && al == 3'h2;
  endsequence
  // ****
  // Properties
  // ****
  a_deselect_quiet: assert property (cs_n |=> $stable(mode_regs) && ((bank_open & ~$past(bank_open)) == '0))
    else $error("deselect changed state");
  a_mode_load_value: assert property (live && code == 3'h0 |=> mode_regs[$past(ba)] == $past(addr))
    else $error("mode register not loaded");
  a_mode_gap_busy: assert property (live && code == 3'h0 |=> mode_busy ##1 mode_busy ##1 !mode_busy)
    else $error("mode set gap not flagged");
  a_activate_opens: assert property (live && code == 3'h3 && !bank_open[ba] && !bank_precharging[ba] |=> bank_open[$past(ba)])
    else $error("activate did not open bank");
  a_close_via_precharge: assert property ($fell(bank_open[0]) |-> bank_precharging[0])
    else $error("bank closed without precharge");
  a_read_column: assert property (live && code == 3'h5 && al == 3'h0 |-> ##2 array_rd_en && ({4'h0, array_col} == ($past(addr, 2) & 14'h03FF)) && array_bank == $past(ba, 2))
    else $error("read beat wrong");
  a_posted_read: assert property (rd_late |-> ##2 !array_rd_en ##2 array_rd_en)
    else $error("posted read latency wrong");
  a_write_mask_beat: assert property (wr_cmd ##1 1'b1 |=> (array_wr_en == !$past(write_byte_mask)) && (!array_wr_en || array_wr_data == $past(wr_data)))
    else $error("write beat mask wrong");
  a_precharge_all: assert property (live && code == 3'h2 && addr[AP_BIT] |=> bank_open == '0)
    else $error("precharge all left a row open");
  a_refresh_count: assert property (live && code == 3'h1 |=> refresh_pulse && refresh_row == $past(refresh_row) + 14'h1)
    else $error("refresh row not advanced");
  a_selfref_entry: assert property (cke_q && !cke && !cs_n && code == 3'h1 && idle && !selfref_active && !powerdown_active |=> selfref_active && !dll_enable && refresh_pulse)
    else $error("self refresh entry wrong");
  a_term_selfref_off: assert property (selfref_active && $past(selfref_active) |-> !term_enable)
    else $error("termination on in self refresh");
endmodule
bind ddr2_command_bank_protocol ddr2_cmd_checker chk_inst (.*);

// File: sim/tb.sv
`timescale 1ns/1ps
module tb
  import ddr2_cmd_pkg::*;
;
  typedef struct packed {
    logic [1:0] b;
    logic [13:0] row;
    logic [9:0] col;
    logic ap;
    logic [3:0] m;
    logic [7:0] d;
  } case_t;
  logic core_clk, resetn, termination_control, cke, cs_n, ras_n, cas_n, we_n;
  logic [BA_W-1:0] ba, array_bank;
  logic [ADDR_W-1:0] addr, refresh_row, array_row, rr;
  logic [DATA_W-1:0] wr_data, array_wr_data;
  logic write_byte_mask, mode_busy, selfref_active, powerdown_active, dll_enable;
  logic term_enable, refresh_pulse, array_wr_en, array_rd_en;
  logic [NUM_BANKS-1:0] bank_open, bank_precharging;
  logic [NUM_MODE_REGS-1:0][ADDR_W-1:0] mode_regs;
  logic [COL_W-1:0] array_col;
  logic [34:0] seen [$];
  logic [34:0] exp_q [$];
  int miscompares = 0;
  int cmp_count = 0;
  case_t rows [4] = '{{2'h0, 14'h1A2B, 10'h3FE, 1'b1, 4'h0, 8'h10},
                      {2'h1, 14'h3FFF, 10'h000, 1'b0, 4'h5, 8'hA0},
                      {2'h2, 14'h0001, 10'h155, 1'b1, 4'hF, 8'h5A},
                      {2'h3, 14'h2000, 10'h3FF, 1'b0, 4'h8, 8'hF0}};
  ddr2_command_bank_protocol ddr2_command_bank_protocol_inst (.*);
  ctrl_model ctrl_model_inst (.*);
  initial core_clk = 1'b0;
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk)
    if (array_wr_en || array_rd_en)
      seen.push_back({array_wr_en, array_bank, array_row, array_col,
                      array_wr_en ? array_wr_data : 8'h00});
  // ****
  // Helpers
  // ****
  task check(input string what, input logic [63:0] exp, input logic [63:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      $display("unexpected %s: expected %0h seen %0h", what, exp, got);
      miscompares++;
    end
  endtask
  task complete_run;
    $display("compares %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task bound(input int n);
    if (n >= 12)
    begin
      miscompares++;
      complete_run();
    end
  endtask
  task cmp_beats;
    check("beat count", exp_q.size(), seen.size());
    while (exp_q.size() > 0 && seen.size() > 0) check("beat", exp_q.pop_front(), seen.pop_front());
    exp_q.delete();
    seen.delete();
  endtask
  // ****
  // Sequence
  // ****
  initial
  begin
    int n;
    int k;
    case_t r;
    resetn = 1'b0;
    termination_control = 1'b0;
    repeat (10) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge core_clk);
    check("bank_open", 0, bank_open);
    check("dll_enable", 1, dll_enable);
    check("mode_regs", 0, mode_regs);
    check("term_enable", 0, term_enable);
    $display("reset test done");
    foreach (rows[i])
    begin
      r = rows[i];
      ctrl_model_inst.issue(1'b0, 3'h3, r.b, r.row, 1'b1);
      #1 check("opened", 1, bank_open[r.b]);
      for (k = 0; k < 4; k++)
        if (!r.m[k]) exp_q.push_back({1'b1, r.b, r.row, 10'(r.col + k), 8'(r.d + k)});
      for (k = 0; k < 4; k++) exp_q.push_back({1'b0, r.b, r.row, 10'(r.col + k), 8'h00});
      ctrl_model_inst.issue(1'b0, 3'h4, r.b, {4'h0, r.col}, 1'b1);
      ctrl_model_inst.beats(r.d, r.m);
      ctrl_model_inst.issue(1'b0, 3'h5, r.b, {3'h0, r.ap, r.col}, 1'b1);
      repeat (ROW_PRECHARGE_CYC + 6) @(posedge core_clk);
      #1 check("open after read", !r.ap, bank_open[r.b]);
      if (!r.ap) ctrl_model_inst.issue(1'b0, 3'h2, r.b, 14'h0000, 1'b1);
      repeat (ROW_PRECHARGE_CYC + 2) @(posedge core_clk);
      #1 check("idle", 0, bank_open[r.b] | bank_precharging[r.b]);
      cmp_beats();
      $display("table row %0d done", i);
    end
    ctrl_model_inst.issue(1'b1, 3'h0, 2'h1, 14'h3FFF, 1'b1);
    repeat (2) @(posedge core_clk);
    #1 check("mode after deselect", 0, mode_regs);
    rr = refresh_row;
    ctrl_model_inst.issue(1'b0, 3'h1, 2'h3, 14'h2A5C, 1'b1);
    repeat (2) @(posedge core_clk);
    #1 check("refresh row", rr + 14'h1, refresh_row);
    ctrl_model_inst.mode_load(2'h1, 14'h0014);
    #1 check("ext mode", 14'h0014, mode_regs[EXT_MODE_IDX]);
    ctrl_model_inst.issue(1'b0, 3'h3, 2'h0, 14'h0005, 1'b1);
    ctrl_model_inst.issue(1'b0, 3'h5, 2'h0, 14'h0010, 1'b1);
    n = 0;
    do begin @(negedge core_clk); n++; end while (array_rd_en !== 1'b1 && n < 12);
    check("posted latency", 4, n);
    bound(n);
    repeat (6) @(posedge core_clk);
    ctrl_model_inst.issue(1'b0, 3'h2, 2'h0, 14'h0000, 1'b1);
    repeat (ROW_PRECHARGE_CYC + 2) @(posedge core_clk);
    seen.delete();
    $display("mode and posted test done");
    ctrl_model_inst.mode_load(2'h1, 14'h0004);
    @(posedge core_clk);
    termination_control <= 1'b1;
    n = 0;
    do begin @(negedge core_clk); n++; end while (term_enable !== 1'b1 && n < 12);
    check("term on", TERM_ON_DELAY_CYC + 4, n);
    bound(n);
    ctrl_model_inst.issue(1'b0, 3'h1, 2'h0, 14'h0000, 1'b0);
    check("selfref", 1, selfref_active);
    check("dll off", 0, dll_enable);
    check("term in selfref", 0, term_enable);
    ctrl_model_inst.wake();
    check("dll on", 1, dll_enable);
    ctrl_model_inst.issue(1'b0, 3'h7, 2'h0, 14'h0000, 1'b0);
    check("powerdown", 1, powerdown_active);
    check("term in powerdown", 1, term_enable);
    @(posedge core_clk);
    termination_control <= 1'b0;
    n = 0;
    do begin @(negedge core_clk); n++; end while (term_enable !== 1'b0 && n < 12);
    check("term off fast", 4, n);
    bound(n);
    ctrl_model_inst.issue(1'b1, 3'h7, 2'h0, 14'h0000, 1'b1);
    check("powerdown exit", 0, powerdown_active);
    $display("termination test done");
    ctrl_model_inst.issue(1'b0, 3'h3, 2'h0, 14'h0001, 1'b1);
    ctrl_model_inst.issue(1'b0, 3'h3, 2'h1, 14'h0002, 1'b1);
    ctrl_model_inst.issue(1'b0, 3'h2, 2'h0, 14'h0400, 1'b1);
    #1 check("all closed", 0, bank_open);
    ctrl_model_inst.issue(1'b0, 3'h2, 2'h0, 14'h0000, 1'b1);
    n = 0;
    do begin @(negedge core_clk); n++; end while (bank_precharging[0] === 1'b1 && n < 12);
    check("restart", 1, n >= ROW_PRECHARGE_CYC && n <= ROW_PRECHARGE_CYC + 2);
    bound(n);
    ctrl_model_inst.issue(1'b0, 3'h3, 2'h3, 14'h0009, 1'b1);
    ctrl_model_inst.issue(1'b0, 3'h3, 2'h2, 14'h0007, 1'b1);
    ctrl_model_inst.issue(1'b0, 3'h4, 2'h2, 14'h0420, 1'b1);
    ctrl_model_inst.beats(8'h33, 4'h0);
    ctrl_model_inst.issue(1'b0, 3'h5, 2'h3, 14'h0040, 1'b1);
    #1 check("auto precharging", 1, bank_precharging[2]);
    repeat (ROW_PRECHARGE_CYC + 6) @(posedge core_clk);
    #1 check("write auto precharge", 0, bank_open[2] | bank_precharging[2]);
    check("other bank open", 1, bank_open[3]);
    check("write and read beats", 8, seen.size());
    $display("precharge test done");
    complete_run();
  end
endmodule
